// ===== design/sfr_regs.sv
/*
 * System flags and descriptor table locator registers.
 * Holds the processor flags word, the global, local and vector table
 * locators, and derives single-step, interrupt acceptance, I/O access,
 * resume and alignment-check decisions. Assumes one retire per cycle
 * and that the descriptor image for local loads is already fetched.
 */
`default_nettype none


module sfr_regs (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	// Retire stage
	input  wire sfr_pkg::sfr_retire_type retire,
	// Privilege and control state
	input  wire logic [1:0]             current_priv_level,
	input  wire logic [31:0]            control_reg_zero,
	input  wire logic [31:0]            control_reg_four_vme,
	// Pending events
	input  wire sfr_pkg::sfr_event_type  evt,
	// Flags and locators
	output var  logic [31:0]            processor_flags_word_r,
	output var  sfr_pkg::sfr_tbl_type    global_table_locator_r,
	output var  sfr_pkg::sfr_desc_type   local_table_locator_r,
	output var  sfr_pkg::sfr_tbl_type    vector_table_locator_r,
	// Store results
	output var  logic [47:0]            store_data_r,
	output var  logic                   store_valid_r,
	// Decisions
	output var  logic                   single_step_exc_r,
	output var  logic                   maskable_accept_r,
	output var  logic                   nmi_accept_r,
	output var  logic                   exc_accept_r,
	output var  logic                   bkpt_exc_r,
	output var  logic                   io_allowed_r,
	output var  logic                   align_exc_r,
	output var  logic                   v86_mode_r,
	output var  logic                   virt_int_enable_r,
	output var  logic                   virt_int_pend_r
);

	// ---------------------------------------------------------------
	// Retire decode
	// ---------------------------------------------------------------
	logic        is_pop;
	logic        is_ret;
	logic        is_task;
	logic        is_kernel;
	logic        virt_ok;
	logic        align_on;
	logic        misaligned;
	logic        trap_armed_r;
	logic [31:0] flags_nxt;
	logic [31:0] img;

	// Maskable acceptance, shared by decision and resume logic
	function automatic logic maskable_take();
		maskable_take = evt.maskable_req && processor_flags_word_r[sfr_pkg::SFR_IE_BIT];
	endfunction : maskable_take

	// Instruction class flags for the retiring slot
	always_comb begin
		is_pop    = retire.valid && (retire.op == sfr_pkg::SFR_OP_FLAGS_POP ||
		                             retire.op == sfr_pkg::SFR_OP_FLAGS_POP_DW);
		is_ret    = retire.valid && retire.op == sfr_pkg::SFR_OP_INT_RETURN;
		is_task   = retire.valid && retire.op == sfr_pkg::SFR_OP_TASK_SWITCH;
		is_kernel = current_priv_level == sfr_pkg::SFR_PRIV_KERNEL;
		img       = retire.flags_img;
	end

	// ---------------------------------------------------------------
	// Flags word next value
	// ---------------------------------------------------------------
	always_comb begin
		flags_nxt = processor_flags_word_r;
		if (is_pop || is_ret) begin
			// Plain writable bits incl. trap, interrupt enable, nested, v86, AC, VIRTUAL_INT_FLAG, VIRTUAL_INT_PENDING, ID
			flags_nxt = (processor_flags_word_r & ~sfr_pkg::SFR_FLAGS_WMASK)
			          | (img & sfr_pkg::SFR_FLAGS_WMASK);
			flags_nxt[sfr_pkg::SFR_RESUME_BIT] = processor_flags_word_r[sfr_pkg::SFR_RESUME_BIT];
			if (is_ret)
				flags_nxt[sfr_pkg::SFR_RESUME_BIT] = img[sfr_pkg::SFR_RESUME_BIT];
			// I/O field only replaced at kernel level
			if (!is_kernel)
				flags_nxt[sfr_pkg::SFR_IO_PRIVILEGE_FIELD_HI_BIT:sfr_pkg::SFR_IO_PRIVILEGE_FIELD_LO_BIT] =
					processor_flags_word_r[sfr_pkg::SFR_IO_PRIVILEGE_FIELD_HI_BIT:sfr_pkg::SFR_IO_PRIVILEGE_FIELD_LO_BIT];
			// Returning from a nested task clears the link
			if (is_ret && retire.nested_ret)
				flags_nxt[sfr_pkg::SFR_NT_BIT] = 1'b0;
		end else if (is_task) begin
			// Task entered by call, interrupt or exception links back
			if (retire.task_link)
				flags_nxt[sfr_pkg::SFR_NT_BIT] = 1'b1;
		end else if (retire.valid) begin
			// Successful completion clears resume
			flags_nxt[sfr_pkg::SFR_RESUME_BIT] = 1'b0;
		end
		// Exception entry sets resume, except for the debug exception; so does a maskable interrupt taken on a string instruction
		if ((evt.exc_req && !evt.exc_is_debug) ||
		    (maskable_take() && retire.op == sfr_pkg::SFR_OP_STRING && retire.valid))
			flags_nxt[sfr_pkg::SFR_RESUME_BIT] = 1'b1;
	end

	// Flags word storage
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			processor_flags_word_r <= sfr_pkg::SFR_FLAGS_RST;
		else
			processor_flags_word_r <= flags_nxt;
	end

	// ---------------------------------------------------------------
	// Single step tracking
	// ---------------------------------------------------------------
	// Trap raised after each instruction retired with trap already armed
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			trap_armed_r      <= 1'b0;
			single_step_exc_r <= 1'b0;
		end else begin
			single_step_exc_r <= retire.valid && trap_armed_r
			                     && processor_flags_word_r[sfr_pkg::SFR_TRAP_BIT];
			if (retire.valid) begin
				// Setting instruction itself does not trap; the next one does
				trap_armed_r <= flags_nxt[sfr_pkg::SFR_TRAP_BIT];
			end
			if (!flags_nxt[sfr_pkg::SFR_TRAP_BIT])
				trap_armed_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Event decisions
	// ---------------------------------------------------------------
	always_comb begin
		virt_ok    = control_reg_four_vme[0] &&
		             processor_flags_word_r[sfr_pkg::SFR_IO_PRIVILEGE_FIELD_HI_BIT:sfr_pkg::SFR_IO_PRIVILEGE_FIELD_LO_BIT] < 2'h3;
		align_on   = processor_flags_word_r[sfr_pkg::SFR_ALIGN_BIT] && control_reg_zero[sfr_pkg::SFR_AM_BIT];
		misaligned = (evt.mem_size == 2'h1 && evt.mem_addr_lo[0]) ||
		             (evt.mem_size == 2'h2 && evt.mem_addr_lo != 2'h0);
	end

	// Registered decisions toward the core
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			maskable_accept_r <= 1'b0;
			nmi_accept_r      <= 1'b0;
			exc_accept_r      <= 1'b0;
			bkpt_exc_r        <= 1'b0;
			io_allowed_r      <= 1'b0;
			align_exc_r       <= 1'b0;
			v86_mode_r        <= 1'b0;
			virt_int_enable_r <= 1'b0;
			virt_int_pend_r   <= 1'b0;
		end else begin
			maskable_accept_r <= maskable_take();
			nmi_accept_r      <= evt.nmi_req;
			exc_accept_r      <= evt.exc_req;
			bkpt_exc_r        <= evt.bkpt_hit && !processor_flags_word_r[sfr_pkg::SFR_RESUME_BIT];
			io_allowed_r      <= evt.io_ref && (current_priv_level <=
			                     processor_flags_word_r[sfr_pkg::SFR_IO_PRIVILEGE_FIELD_HI_BIT:sfr_pkg::SFR_IO_PRIVILEGE_FIELD_LO_BIT]);
			align_exc_r       <= evt.mem_ref && misaligned && align_on
			                     && current_priv_level == sfr_pkg::SFR_PRIV_USER && !evt.mem_implicit;
			v86_mode_r        <= processor_flags_word_r[sfr_pkg::SFR_V86_BIT];
			virt_int_enable_r <= virt_ok && processor_flags_word_r[sfr_pkg::SFR_VIF_BIT];
			virt_int_pend_r   <= virt_ok && processor_flags_word_r[sfr_pkg::SFR_VIP_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Table locators
	// ---------------------------------------------------------------
	sfr_pkg::sfr_tbl_type gt_cur;
	sfr_pkg::sfr_tbl_type vt_cur;

	// Global table locator
	sfr_tbl_reg u_global (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.load_en  (retire.valid && retire.op == sfr_pkg::SFR_OP_GT_LOAD),
		.load_val (retire.tbl_img),
		.cur_r    (gt_cur)
	);

	// Vector table locator
	sfr_tbl_reg u_vector (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.load_en  (retire.valid && retire.op == sfr_pkg::SFR_OP_VT_LOAD),
		.load_val (retire.tbl_img),
		.cur_r    (vt_cur)
	);

	// Output copies so every output is a flop
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			global_table_locator_r <= '{base: sfr_pkg::SFR_BASE_RST, limit: sfr_pkg::SFR_LIMIT16_RST};
			vector_table_locator_r <= '{base: sfr_pkg::SFR_BASE_RST, limit: sfr_pkg::SFR_LIMIT16_RST};
		end else begin
			global_table_locator_r <= gt_cur;
			vector_table_locator_r <= vt_cur;
		end
	end

	// Local locator: selector load or task switch brings the whole descriptor
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			local_table_locator_r.sel   <= sfr_pkg::SFR_SEL_RST;
			local_table_locator_r.base  <= sfr_pkg::SFR_BASE_RST;
			local_table_locator_r.limit <= sfr_pkg::SFR_LIMIT32_RST;
			local_table_locator_r.attr  <= sfr_pkg::SFR_ATTR_RST;
		end else if (retire.valid && (retire.op == sfr_pkg::SFR_OP_LT_LOAD)) begin
			local_table_locator_r <= retire.desc_img;
		end else if (is_task) begin
			local_table_locator_r <= retire.desc_img;
		end
	end

	// ---------------------------------------------------------------
	// Store results
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			store_data_r  <= 48'h0000_0000_0000;
			store_valid_r <= 1'b0;
		end else begin
			store_valid_r <= retire.valid && (retire.op == sfr_pkg::SFR_OP_GT_STORE ||
			                 retire.op == sfr_pkg::SFR_OP_LT_STORE || retire.op == sfr_pkg::SFR_OP_VT_STORE);
			unique case (retire.op)
				sfr_pkg::SFR_OP_GT_STORE: store_data_r <= gt_cur;
				sfr_pkg::SFR_OP_VT_STORE: store_data_r <= vt_cur;
				sfr_pkg::SFR_OP_LT_STORE: store_data_r <= {32'h0000_0000, local_table_locator_r.sel};
				default:                  store_data_r <= store_data_r;
			endcase
		end
	end

endmodule : sfr_regs

`default_nettype wire

// ===== design/sfr_tbl_reg.sv
/*
 * One base and limit table locator (global or vector table).
 * Assumes load strobes come from the retire stage on core_clk.
 */
`default_nettype none

module sfr_tbl_reg (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// Load port
	input  wire logic              load_en,
	input  wire sfr_pkg::sfr_tbl_type load_val,
	// Current contents
	output var  sfr_pkg::sfr_tbl_type cur_r
);

	// Whole pair loads in one edge, reset forces base 0 limit ffff
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_r.base  <= sfr_pkg::SFR_BASE_RST;
			cur_r.limit <= sfr_pkg::SFR_LIMIT16_RST;
		end else if (load_en) begin
			cur_r <= load_val;
		end
	end

endmodule : sfr_tbl_reg

`default_nettype wire

// ===== shared/sfr_pkg.sv
/*
 * Shared definitions for the system flags and table locator block:
 * flag bit positions, reset values, operation codes and carrier structs.
 * Assumes the core retires at most one instruction per core_clk cycle.
 */
`default_nettype none

package sfr_pkg;

	// ---------------------------------------------------------------
	// Flag bit positions in the processor flags word, and the AM bit in control_reg_zero
	// ---------------------------------------------------------------
	localparam int SFR_TRAP_BIT     = 8;
	localparam int SFR_IE_BIT       = 9;
	localparam int SFR_IO_PRIVILEGE_FIELD_LO_BIT  = 12;
	localparam int SFR_IO_PRIVILEGE_FIELD_HI_BIT  = 13;
	localparam int SFR_NT_BIT       = 14;
	localparam int SFR_RESUME_BIT   = 16;
	localparam int SFR_V86_BIT      = 17;
	localparam int SFR_ALIGN_BIT    = 18;
	localparam int SFR_VIF_BIT      = 19;
	localparam int SFR_VIP_BIT      = 20;
	localparam int SFR_ID_BIT       = 21;
	localparam int SFR_AM_BIT       = 18;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] SFR_FLAGS_RST   = 32'h0000_0002;
	localparam logic [31:0] SFR_BASE_RST    = 32'h0000_0000;
	localparam logic [15:0] SFR_LIMIT16_RST = 16'hffff;
	localparam logic [31:0] SFR_LIMIT32_RST = 32'h0000_ffff;
	localparam logic [15:0] SFR_SEL_RST     = 16'h0000;
	localparam logic [15:0] SFR_ATTR_RST    = 16'h0000;
	// Writable flag bits: status bits 0, 2, 4, 6..11 and system bits 12..14, 16..21
	localparam logic [31:0] SFR_FLAGS_WMASK = 32'h003f_7fd5;
	localparam logic [1:0]  SFR_PRIV_KERNEL = 2'h0;
	localparam logic [1:0]  SFR_PRIV_USER   = 2'h3;

	// ---------------------------------------------------------------
	// Retired instruction classes seen by the block
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SFR_OP_OTHER,
		SFR_OP_FLAGS_POP,
		SFR_OP_FLAGS_POP_DW,
		SFR_OP_INT_RETURN,
		SFR_OP_GT_LOAD,
		SFR_OP_GT_STORE,
		SFR_OP_LT_LOAD,
		SFR_OP_LT_STORE,
		SFR_OP_VT_LOAD,
		SFR_OP_VT_STORE,
		SFR_OP_TASK_SWITCH,
		SFR_OP_STRING
	} sfr_op_type;

	// Descriptor image handed over with a local table load or task switch
	typedef struct packed {
		logic [15:0] sel;
		logic [31:0] base;
		logic [31:0] limit;
		logic [15:0] attr;
	} sfr_desc_type;

	// Base and limit pair of a global or vector table locator
	typedef struct packed {
		logic [31:0] base;
		logic [15:0] limit;
	} sfr_tbl_type;

	// One retiring instruction
	typedef struct packed {
		logic        valid;
		sfr_op_type  op;
		logic [31:0] flags_img;
		sfr_tbl_type tbl_img;
		sfr_desc_type desc_img;
		logic        task_link;
		logic        nested_ret;
	} sfr_retire_type;

	// Pending events arriving from the rest of the core
	typedef struct packed {
		logic       maskable_req;
		logic       nmi_req;
		logic       exc_req;
		logic       exc_is_debug;
		logic       bkpt_hit;
		logic       mem_ref;
		logic       mem_implicit;
		logic [1:0] mem_size;
		logic [1:0] mem_addr_lo;
		logic       io_ref;
	} sfr_event_type;

endpackage : sfr_pkg

`default_nettype wire

// ===== verif/sfr_regs_assertions.sv
/*
 * Concurrent checks on the flags and table locator block ports.
 * Assumes binding onto sfr_regs with core_clk and active-low rst_b.
 */
`default_nettype none

module sfr_chk (
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    rst_b,
	// Watched inputs
	input wire sfr_pkg::sfr_retire_type retire,
	input wire logic [1:0]              current_priv_level,
	input wire logic [31:0]             control_reg_zero,
	input wire logic [31:0]             control_reg_four_vme,
	input wire sfr_pkg::sfr_event_type  evt,
	// Watched outputs
	input wire logic [31:0]             processor_flags_word_r,
	input wire logic                    store_valid_r,
	input wire logic                    single_step_exc_r,
	input wire logic                    maskable_accept_r,
	input wire logic                    nmi_accept_r,
	input wire logic                    bkpt_exc_r,
	input wire logic                    io_allowed_r,
	input wire logic                    align_exc_r,
	input wire logic                    virt_int_enable_r,
	input wire logic                    virt_int_pend_r
);
	// ---------------------------------------------------------------
	// Port relations
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	step_needs_trap_a: assert property (single_step_exc_r |-> $past(processor_flags_word_r[8])
		|| $past(processor_flags_word_r[8], 2)) else $error("single step without trap flag");
	mask_gate_a: assert property (maskable_accept_r |-> $past(evt.maskable_req && processor_flags_word_r[9]))
		else $error("maskable accepted while inhibited");
	nmi_free_a: assert property ($past(evt.nmi_req) |-> nmi_accept_r) else $error("nmi not accepted");
	io_level_a: assert property (io_allowed_r |-> $past(current_priv_level <= processor_flags_word_r[13:12]))
		else $error("io allowed above field");
	io_privilege_field_hold_a: assert property (retire.valid && current_priv_level != 2'h0 && (retire.op == sfr_pkg::SFR_OP_FLAGS_POP
		|| retire.op == sfr_pkg::SFR_OP_INT_RETURN) |=> $stable(processor_flags_word_r[13:12]))
		else $error("io field changed off level zero");
	bkpt_resume_a: assert property (bkpt_exc_r |-> !$past(processor_flags_word_r[16]))
		else $error("breakpoint taken with resume set");
	pop_resume_a: assert property (retire.valid && retire.op == sfr_pkg::SFR_OP_FLAGS_POP && !evt.exc_req
		&& !evt.maskable_req |=> !$rose(processor_flags_word_r[16])) else $error("pop set resume");
	align_user_a: assert property (align_exc_r |-> $past(current_priv_level == 2'h3 && !evt.mem_implicit
		&& control_reg_zero[18] && processor_flags_word_r[18])) else $error("align fault not allowed");
	virt_gate_a: assert property (!control_reg_four_vme[0] && $past(!control_reg_four_vme[0])
		|-> !virt_int_enable_r && !virt_int_pend_r) else $error("virtual flags seen without extensions");
	store_cause_a: assert property (store_valid_r |-> $past(retire.valid) || $past(retire.valid, 2))
		else $error("store result without request");
endmodule : sfr_chk

`default_nettype wire

// ===== verif/tb.sv
/*
 * Self-checking bench for sfr_regs: resets, then runs one task per scenario.
 * Assumes inputs change on the falling edge and outputs are read there.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	sfr_pkg::sfr_retire_type retire = '0;
	sfr_pkg::sfr_event_type  evt = '0;
	logic [1:0]  current_priv_level = 2'h0;
	logic [31:0] control_reg_zero = 32'h0;
	logic [31:0] control_reg_four_vme = 32'h0;
	logic [31:0] processor_flags_word_r;
	sfr_pkg::sfr_tbl_type  global_table_locator_r, vector_table_locator_r;
	sfr_pkg::sfr_desc_type local_table_locator_r;
	logic [47:0] store_data_r;
	logic store_valid_r, single_step_exc_r, maskable_accept_r, nmi_accept_r, exc_accept_r, bkpt_exc_r;
	logic io_allowed_r, align_exc_r, v86_mode_r, virt_int_enable_r, virt_int_pend_r;
	int err_count = 0;
	int tests_run = 0;
	wire logic [6:0] dec = {single_step_exc_r, maskable_accept_r, nmi_accept_r, exc_accept_r, bkpt_exc_r,
		io_allowed_r, align_exc_r};

	sfr_regs dut (.*);
	// Clock at 40 MHz
	always #12.5 core_clk = ~core_clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic final_report;
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [95:0] seen, input logic [95:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// One retiring instruction, one cycle long
	task automatic ret(input sfr_pkg::sfr_op_type op, input logic [31:0] f);
		retire.valid = 1'b1;
		retire.op = op;
		retire.flags_img = f;
		@(negedge core_clk);
		retire.valid = 1'b0;
	endtask : ret
	// Decision pulse seen within three samples
	task automatic win(input string n, input int i, input logic e);
		logic h;
		h = dec[i];
		repeat (2) begin
			@(negedge core_clk);
			h = h | dec[i];
		end
		chk(n, h, e);
	endtask : win
	// Store request, bounded wait for its result
	task automatic st(input sfr_pkg::sfr_op_type op, input logic [47:0] e);
		int i;
		ret(op, 32'h0);
		for (i = 0; i < 4 && store_valid_r !== 1'b1; i++) @(negedge core_clk);
		if (store_valid_r !== 1'b1) begin
			err_count++;
			final_report();
		end
		chk("store", store_data_r, e);
	endtask : st

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic tables;
		chk("flags", processor_flags_word_r, 32'h2);
		chk("gt", global_table_locator_r, {32'h0, 16'hffff});
		chk("vt", vector_table_locator_r, {32'h0, 16'hffff});
		chk("lt", local_table_locator_r, {16'h0, 32'h0, 32'hffff, 16'h0});
		retire.tbl_img = {32'h1234_5678, 16'h00ab};
		ret(sfr_pkg::SFR_OP_GT_LOAD, 32'h0);
		retire.tbl_img = {32'h9abc_def0, 16'h07ff};
		ret(sfr_pkg::SFR_OP_VT_LOAD, 32'h0);
		chk("gt", global_table_locator_r, {32'h1234_5678, 16'h00ab});
		@(negedge core_clk);
		chk("vt", vector_table_locator_r, {32'h9abc_def0, 16'h07ff});
		st(sfr_pkg::SFR_OP_GT_STORE, {32'h1234_5678, 16'h00ab});
		st(sfr_pkg::SFR_OP_VT_STORE, {32'h9abc_def0, 16'h07ff});
		retire.desc_img = {16'h0018, 32'hbeef_0000, 32'h0fff, 16'h0082};
		ret(sfr_pkg::SFR_OP_LT_LOAD, 32'h0);
		chk("lt", local_table_locator_r, {16'h0018, 32'hbeef_0000, 32'h0fff, 16'h0082});
		st(sfr_pkg::SFR_OP_LT_STORE, 48'h0018);
		retire.desc_img = {16'h0028, 32'h0004_0000, 32'h00ff, 16'h0082};
		retire.task_link = 1'b1;
		ret(sfr_pkg::SFR_OP_TASK_SWITCH, 32'h2);
		retire.task_link = 1'b0;
		chk("lt", local_table_locator_r, {16'h0028, 32'h0004_0000, 32'h00ff, 16'h0082});
		chk("nt", processor_flags_word_r[14], 1'b1);
	endtask : tables

	task automatic sys_flags;
		current_priv_level = 2'h3;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0001_3002);
		chk("io_privilege_field", processor_flags_word_r[13:12], 2'h0);
		current_priv_level = 2'h0;
		ret(sfr_pkg::SFR_OP_FLAGS_POP_DW, 32'h0021_7002);
		chk("pop", {processor_flags_word_r[21], processor_flags_word_r[16:12]}, 6'h27);
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0000_2002);
		chk("pop", {processor_flags_word_r[21], processor_flags_word_r[14:12]}, 4'h2);
		win("step", 6, 1'b0);
		evt.io_ref = 1'b1;
		current_priv_level = 2'h2;
		win("io", 1, 1'b1);
		current_priv_level = 2'h3;
		@(negedge core_clk);
		win("io", 1, 1'b0);
		evt.io_ref = 1'b0;
		current_priv_level = 2'h0;
		control_reg_four_vme = 32'h1;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h001a_0002);
		@(negedge core_clk);
		chk("virt", {v86_mode_r, virt_int_enable_r, virt_int_pend_r}, 3'h7);
		control_reg_four_vme = 32'h0;
		repeat (2) @(negedge core_clk);
		chk("virt", {virt_int_enable_r, virt_int_pend_r}, 2'h0);
	endtask : sys_flags

	task automatic events;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0000_0202);
		evt.maskable_req = 1'b1;
		win("mask", 5, 1'b1);
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h2);
		@(negedge core_clk);
		win("mask", 5, 1'b0);
		evt = '0;
		evt.nmi_req = 1'b1;
		evt.exc_req = 1'b1;
		win("nmi", 4, 1'b1);
		win("exc", 3, 1'b1);
		chk("rf", processor_flags_word_r[16], 1'b1);
		evt = '0;
		ret(sfr_pkg::SFR_OP_OTHER, 32'h0);
		chk("rf", processor_flags_word_r[16], 1'b0);
		ret(sfr_pkg::SFR_OP_INT_RETURN, 32'h0001_0002);
		chk("rf", processor_flags_word_r[16], 1'b1);
		evt.bkpt_hit = 1'b1;
		win("bkpt", 2, 1'b0);
		ret(sfr_pkg::SFR_OP_OTHER, 32'h0);
		chk("rf", processor_flags_word_r[16], 1'b0);
		win("bkpt", 2, 1'b1);
		evt = '0;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0004_0002);
		control_reg_zero = 32'h0004_0000;
		current_priv_level = 2'h3;
		evt.mem_ref = 1'b1;
		evt.mem_size = 2'h1;
		evt.mem_addr_lo = 2'h1;
		win("align", 0, 1'b1);
		evt.mem_implicit = 1'b1;
		@(negedge core_clk);
		win("align", 0, 1'b0);
		evt.mem_implicit = 1'b0;
		control_reg_zero = 32'h0;
		@(negedge core_clk);
		win("align", 0, 1'b0);
		evt = '0;
		current_priv_level = 2'h0;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0000_0202);
		evt.maskable_req = 1'b1;
		ret(sfr_pkg::SFR_OP_STRING, 32'h0);
		evt = '0;
		chk("rf", processor_flags_word_r[16], 1'b1);
		retire.nested_ret = 1'b1;
		ret(sfr_pkg::SFR_OP_INT_RETURN, 32'h0000_4002);
		retire.nested_ret = 1'b0;
		chk("nt", processor_flags_word_r[14], 1'b0);
	endtask : events

	task automatic trap;
		ret(sfr_pkg::SFR_OP_FLAGS_POP, 32'h0000_0102);
		win("step", 6, 1'b0);
		ret(sfr_pkg::SFR_OP_OTHER, 32'h0);
		win("step", 6, 1'b1);
	endtask : trap

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(negedge core_clk);
		rst_b = 1'b1;
		tables();
		sys_flags();
		events();
		trap();
		final_report();
	end
endmodule : tb

bind sfr_regs sfr_chk u_chk (.*);

`default_nettype wire
